// ---- led_gpio_map.vh ----
// register map, field positions and reset values of the LED/GPIO pin block
`ifndef LED_GPIO_MAP_VH
`define LED_GPIO_MAP_VH

`define CFG_ADDR 12'h024
`define SEL_BIT 31
`define UPPER_FN_HI 25
`define UPPER_FN_LO 24
`define MIDDLE_FN_HI 21
`define MIDDLE_FN_LO 20
`define LOWER_FN_HI 17
`define LOWER_FN_LO 16
`define DRIVE_LO 8
`define DIR_LO 4
`define LEVEL_LO 0
`define FN_GPIO 2'h0
`define FN_LED 2'h1
`define FN_MIRROR_A 2'h2
`define FN_MIRROR_B 2'h3
`define CFG_RESET 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- pin_driver.v ----
// one multi-function pin: output value and push-pull/open-drain enable
`timescale 1ns/10ps
`default_nettype none
`include "led_gpio_map.vh"

module pin_driver (
    // selected function
    input wire [1:0] fn,
    input wire gpio_dir,
    input wire gpio_val,
    input wire push_pull,
    input wire led_val,
    input wire mirror_a,
    input wire mirror_b,
    // pin
    output reg pin_o,
    output reg pin_oe_n
);

    reg val;
    reg drive;
    reg pp;

    always @* begin
        val = gpio_val;
        drive = gpio_dir;
        pp = push_pull;
        case (fn)
            `FN_GPIO: begin
                val = gpio_val;
                drive = gpio_dir;
            end
            `FN_LED: begin
                val = led_val;
                drive = 1'b1;
            end
            // mirrors always push-pull so a high is seen without a pull-up
            `FN_MIRROR_A: begin
                val = mirror_a;
                drive = 1'b1;
                pp = 1'b1;
            end
            `FN_MIRROR_B: begin
                val = mirror_b;
                drive = 1'b1;
                pp = 1'b1;
            end
            default: begin
                val = gpio_val;
                drive = 1'b0;
            end
        endcase
        // open drain only pulls low; a high is left to the pull-up
        pin_o = val;
        pin_oe_n = ~(drive & (pp | ~val));
    end

endmodule
`default_nettype wire

// ---- led_gpio_pin_config.v ----
// LED / GPIO pin configuration register and pin routing for pins 8 to 10
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "led_gpio_map.vh"

module led_gpio_pin_config #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // resets restoring the select bit and eeprom strap
    input wire USB_RESET,
    input wire LITE_RESET,
    input wire EEPROM_PRESENT,
    input wire EEPROM_LED_SELECT,
    // axi4-lite write address
    input wire [ADDR_W-1:0] AWADDR,
    input wire AWVALID,
    output wire AWREADY,
    // axi4-lite write data
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output wire WREADY,
    // axi4-lite write response
    output reg [1:0] BRESP,
    output reg BVALID,
    input wire BREADY,
    // axi4-lite read address
    input wire [ADDR_W-1:0] ARADDR,
    input wire ARVALID,
    output wire ARREADY,
    // axi4-lite read data
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    output reg RVALID,
    input wire RREADY,
    // internal status feeding the pins; FULL_DUPLEX feeds none
    input wire LINK_UP,
    input wire ACTIVITY,
    input wire SPEED_100,
    input wire FULL_DUPLEX,
    input wire MII_RXD0,
    input wire MII_RXD1,
    input wire MII_RXD2,
    input wire MII_RXD3,
    input wire MII_CRS,
    input wire PHY_RESET_OUT,
    // pins 8..10, bit 0 is pin 8
    input wire [2:0] PIN_I,
    output wire [2:0] PIN_O,
    output wire [2:0] PIN_OE_N
);

    ////////////////////////////////////////////////////////////////////////
    // configuration state

    reg led_meaning_select_ff;
    reg [1:0] upper_pin_function_ff;
    reg [1:0] middle_pin_function_ff;
    reg [1:0] lower_pin_function_ff;
    reg [2:0] pin_drive_type_ff;
    reg [2:0] pin_direction_ff;
    reg [2:0] pin_data_ff;
    reg [2:0] pin_level_ff;
    reg [ADDR_W-1:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg aw_held_ff;
    reg w_held_ff;

    // value restored by any reset: eeprom flag or zero
    wire sel_default = EEPROM_PRESENT & EEPROM_LED_SELECT;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write path: address and data accepted in either order

    assign AWREADY = ~aw_held_ff & ~BVALID;
    assign WREADY = ~w_held_ff & ~BVALID;

    wire aw_take = AWVALID & AWREADY;
    wire w_take = WVALID & WREADY;
    wire aw_have = aw_held_ff | aw_take;
    wire w_have = w_held_ff | w_take;
    wire [ADDR_W-1:0] wr_addr = aw_held_ff ? aw_addr_ff : AWADDR;
    wire [31:0] wr_data = w_held_ff ? w_data_ff : WDATA;
    wire [3:0] wr_strb = w_held_ff ? w_strb_ff : WSTRB;
    wire wr_fire = aw_have & w_have & ~BVALID;
    // register byte address at bus width, word index compared
    wire [ADDR_W-1:0] cfg_byte_addr = `CFG_ADDR;
    wire wr_hit = wr_addr[ADDR_W-1:2] == cfg_byte_addr[ADDR_W-1:2];
    wire do_write = wr_fire & wr_hit;

    always @(posedge MCLK) begin
        if (RST) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= {ADDR_W{1'b0}};
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_ff <= AWADDR;
            end
            if (w_take) begin
                w_data_ff <= WDATA;
                w_strb_ff <= WSTRB;
            end
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_ff <= 1'b1;
                end
                if (w_take) begin
                    w_held_ff <= 1'b1;
                end
                if (BVALID & BREADY) begin
                    BVALID <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register fields, byte lanes honoured

    always @(posedge MCLK) begin
        if (RST) begin
            led_meaning_select_ff <= sel_default;
            upper_pin_function_ff <= `FN_GPIO;
            middle_pin_function_ff <= `FN_GPIO;
            lower_pin_function_ff <= `FN_GPIO;
            pin_drive_type_ff <= 3'h0;
            pin_direction_ff <= 3'h0;
            pin_data_ff <= 3'h0;
        end else begin
            if (USB_RESET | LITE_RESET) begin
                led_meaning_select_ff <= sel_default;
            end else if (!EEPROM_PRESENT) begin
                led_meaning_select_ff <= 1'b0;
            end else if (do_write & wr_strb[3]) begin
                led_meaning_select_ff <= wr_data[`SEL_BIT];
            end
            if (do_write & wr_strb[3]) begin
                upper_pin_function_ff <=
                    wr_data[`UPPER_FN_HI:`UPPER_FN_LO];
            end
            if (do_write & wr_strb[2]) begin
                middle_pin_function_ff <=
                    wr_data[`MIDDLE_FN_HI:`MIDDLE_FN_LO];
                lower_pin_function_ff <=
                    wr_data[`LOWER_FN_HI:`LOWER_FN_LO];
            end
            if (do_write & wr_strb[1]) begin
                pin_drive_type_ff <= wr_data[`DRIVE_LO+2:`DRIVE_LO];
            end
            if (do_write & wr_strb[0]) begin
                pin_direction_ff <= wr_data[`DIR_LO+2:`DIR_LO];
                pin_data_ff <= wr_data[`LEVEL_LO+2:`LEVEL_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin level sampling for read-back

    always @(posedge MCLK) begin
        if (RST) begin
            pin_level_ff <= 3'h0;
        end else begin
            pin_level_ff <= PIN_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read path, one cycle after the address is taken

    assign ARREADY = ~RVALID;
    wire rd_hit = ARADDR[ADDR_W-1:2] == cfg_byte_addr[ADDR_W-1:2];
    wire [31:0] cfg_word = {led_meaning_select_ff, 5'h00,
        upper_pin_function_ff, 2'h0, middle_pin_function_ff, 2'h0,
        lower_pin_function_ff, 5'h00, pin_drive_type_ff, 1'b0,
        pin_direction_ff, 1'b0, pin_level_ff};

    always @(posedge MCLK) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= `RESP_OKAY;
        end else if (ARVALID & ARREADY) begin
            RVALID <= 1'b1;
            RDATA <= rd_hit ? cfg_word : 32'h00000000;
            RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led meanings; leds are active low on the pin

    wire sel = led_meaning_select_ff;
    wire speed_indicator_pin = ~SPEED_100;
    // select one shows the middle pin as link only
    wire link_activity_pin = sel ? ~LINK_UP
        : ~(LINK_UP & ~ACTIVITY);
    // activity by default; software drives gpio for a duplex light
    wire duplex_indicator_pin = ~ACTIVITY;

    wire [1:0] fn [0:2];
    wire [2:0] led_val;
    wire [2:0] mir_a;
    wire [2:0] mir_b;
    assign fn[0] = lower_pin_function_ff;
    assign fn[1] = middle_pin_function_ff;
    assign fn[2] = upper_pin_function_ff;
    assign led_val = {speed_indicator_pin, link_activity_pin,
        duplex_indicator_pin};
    assign mir_a = {MII_RXD0, MII_RXD1, MII_RXD2};
    assign mir_b = {MII_RXD3, PHY_RESET_OUT, MII_CRS};

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_pin
            pin_driver u_pin (
                .fn(fn[i]),
                .gpio_dir(pin_direction_ff[i]),
                .gpio_val(pin_data_ff[i]),
                .push_pull(pin_drive_type_ff[i]),
                .led_val(led_val[i]),
                .mirror_a(mir_a[i]),
                .mirror_b(mir_b[i]),
                .pin_o(PIN_O[i]),
                .pin_oe_n(PIN_OE_N[i])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// ---- led_gpio_checker_assertions.sv ----
// port-level checks of pin routing for the LED/GPIO block
`timescale 1ns/10ps
`default_nettype none
module led_gpio_checker (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // read answer
    input wire logic BVALID,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    // internal status
    input wire logic LINK_UP,
    input wire logic ACTIVITY,
    input wire logic SPEED_100,
    input wire logic MII_RXD0,
    input wire logic MII_RXD1,
    input wire logic MII_RXD2,
    input wire logic MII_RXD3,
    input wire logic MII_CRS,
    input wire logic PHY_RESET_OUT,
    // pins
    input wire logic [2:0] PIN_O,
    input wire logic [2:0] PIN_OE_N
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    logic rv_ff;
    // a fresh read answer holds the config now driving the pins
    wire logic rd = RVALID && !rv_ff && RRESP == 2'h0 && !BVALID;
    wire logic [1:0] fu = RDATA[25:24];
    wire logic [1:0] fm = RDATA[21:20];
    wire logic [1:0] fl = RDATA[17:16];
    wire logic [2:0] gp = {fu == 2'h0, fm == 2'h0, fl == 2'h0};
    wire logic [2:0] go = gp & RDATA[6:4];
    always @(posedge MCLK) begin
        if (RST) rv_ff <= 1'b0;
        else rv_ff <= RVALID;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_UPPER_MIRROR: assert property (
        rd && fu[1] |-> !PIN_OE_N[2]
        && PIN_O[2] == (fu[0] ? MII_RXD3 : MII_RXD0))
        else $error("upper mirror");
    AST_MIDDLE_MIRROR: assert property (
        rd && fm[1] |-> !PIN_OE_N[1]
        && PIN_O[1] == (fm[0] ? PHY_RESET_OUT : MII_RXD1))
        else $error("middle mirror");
    AST_LOWER_MIRROR: assert property (
        rd && fl[1] |-> !PIN_OE_N[0]
        && PIN_O[0] == (fl[0] ? MII_CRS : MII_RXD2))
        else $error("lower mirror");
    AST_SPEED_LED: assert property (
        rd && fu == 2'h1 |-> PIN_O[2] == !SPEED_100)
        else $error("speed led");
    AST_LINK_LED: assert property (
        rd && fm == 2'h1 |-> PIN_O[1] ==
        (RDATA[31] ? !LINK_UP : !(LINK_UP && !ACTIVITY)))
        else $error("link led");
    AST_ACT_LED: assert property (
        rd && fl == 2'h1 |-> PIN_O[0] == !ACTIVITY)
        else $error("activity led");
    AST_GPIO_IN: assert property (
        rd |-> (gp & ~RDATA[6:4] & ~PIN_OE_N) == 3'h0)
        else $error("input pin driven");
    AST_GPIO_PP: assert property (
        rd |-> (go & RDATA[10:8] & PIN_OE_N) == 3'h0)
        else $error("push-pull not driven");
    AST_GPIO_OD: assert property (
        rd |-> (go & ~RDATA[10:8] & ~PIN_OE_N & PIN_O) == 3'h0)
        else $error("open-drain drives high");
endmodule
`default_nettype wire

// ---- pin_loads.sv ----
// far side of pins 8..10: LED pull-ups and a board driver
`timescale 1ns/10ps
`default_nettype none
module pin_loads (
    // from the block
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe_n,
    // board driver
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    // level back to the block
    output logic [2:0] pin_i
);
    // released pins rise through the pull-up; a clash reads unknown
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!pin_oe_n[i] && ext_en[i]) pin_i[i] = 1'bx;
            else if (!pin_oe_n[i]) pin_i[i] = pin_o[i];
            else pin_i[i] = ext_en[i] ? ext_val[i] : 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// register-level test of the LED/GPIO pin block
`timescale 1ns/10ps
`default_nettype none
`include "led_gpio_map.vh"
module testbench;
    logic MCLK = 0, RST = 1, USB_RESET, LITE_RESET, EEPROM_PRESENT;
    logic EEPROM_LED_SELECT, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic [11:0] AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0;
    logic [3:0] WSTRB = 0;
    logic [9:0] st = 0;
    logic [2:0] ext_en = 0, ext_val = 0, PIN_I;
    wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    wire logic [1:0] BRESP, RRESP;
    wire logic [31:0] RDATA;
    wire logic [2:0] PIN_O, PIN_OE_N;
    int n_mismatch = 0, n_checks = 0;
    always #4 MCLK = ~MCLK;
    led_gpio_pin_config DUT (.MCLK, .RST, .USB_RESET, .LITE_RESET,
        .EEPROM_PRESENT, .EEPROM_LED_SELECT, .AWADDR, .AWVALID, .AWREADY,
        .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
        .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
        .LINK_UP(st[0]), .ACTIVITY(st[1]), .SPEED_100(st[2]),
        .FULL_DUPLEX(st[3]), .MII_RXD0(st[4]), .MII_RXD1(st[5]),
        .MII_RXD2(st[6]), .MII_RXD3(st[7]), .MII_CRS(st[8]),
        .PHY_RESET_OUT(st[9]), .PIN_I, .PIN_O, .PIN_OE_N);
    pin_loads u_load (.pin_o(PIN_O), .pin_oe_n(PIN_OE_N), .ext_en(ext_en),
        .ext_val(ext_val), .pin_i(PIN_I));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        n_checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        @(posedge MCLK);
        aw = 1;
        w = 1;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= 4'hF;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (aw || w) begin
            @(posedge MCLK);
            if (aw && AWREADY) begin
                aw = 0;
                AWVALID <= 1'b0;
            end
            if (w && WREADY) begin
                w = 0;
                WVALID <= 1'b0;
            end
        end
        while (!BVALID) @(posedge MCLK);
        r = BRESP;
        BREADY <= 1'b0;
    endtask
    task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge MCLK); while (!ARREADY);
        ARVALID <= 1'b0;
        do @(posedge MCLK); while (!RVALID);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask
    task rchk(input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        rd(`CFG_ADDR, d, r);
        chk("cfg word", d & m, e & m);
        chk("cfg resp", {30'h0, r}, {30'h0, `RESP_OKAY});
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [9:0] v;
        logic [2:0] e;
        {USB_RESET, LITE_RESET, EEPROM_PRESENT, EEPROM_LED_SELECT} = 0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 0;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        rchk(32'h7, 32'hFFFFFFFF);
        chk("idle oe", PIN_OE_N, 3'h7);
        $display("reset test done");
        wr(12'h100, 32'h1, r);
        chk("bad wr", r, `RESP_SLVERR);
        rd(12'h100, d, r);
        chk("bad rd", r, `RESP_SLVERR);
        $display("unmapped test done");
        wr(`CFG_ADDR, 32'h775, r);
        chk("pp oe", PIN_OE_N, 3'h0);
        chk("pp out", PIN_O, 3'h5);
        rchk(32'h775, 32'hFFFFFFFF);
        wr(`CFG_ADDR, 32'h075, r);
        chk("od oe", PIN_OE_N, 3'h5);
        rchk(32'h075, 32'hFFFFFFFF);
        $display("output test done");
        wr(`CFG_ADDR, 32'h0, r);
        ext_en <= 3'h7;
        ext_val <= 3'h2;
        rchk(32'h2, 32'hFFFFFFFF);
        ext_en <= 3'h0;
        $display("input test done");
        // select writes are ignored without an eeprom
        EEPROM_PRESENT <= 1'b1;
        for (int s = 0; s < 2; s++)
            for (int c = 1; c < 4; c++)
                for (int p = 0; p < 2; p++) begin
                    v = p ? 10'h3C3 : 10'h03C;
                    st <= v;
                    d = {s[0], 5'h0, c[1:0], 2'h0, c[1:0], 2'h0, c[1:0], 16'h0};
                    wr(`CFG_ADDR, d, r);
                    if (c == 1)
                        e = {~v[2], s ? ~v[0] : ~(v[0] & ~v[1]), ~v[1]};
                    else if (c == 2)
                        e = {v[4], v[5], v[6]};
                    else
                        e = {v[7], v[9], v[8]};
                    chk("pin func", PIN_O, e);
                    rchk(d, 32'hFFFF0000);
                end
        $display("function test done");
        for (int k = 0; k < 2; k++) begin
            @(posedge MCLK);
            EEPROM_PRESENT <= k[0];
            EEPROM_LED_SELECT <= 1'b1;
            if (k == 1) USB_RESET <= 1'b1;
            else LITE_RESET <= 1'b1;
            @(posedge MCLK);
            {USB_RESET, LITE_RESET} <= 2'h0;
            rchk({k[0], 31'h0}, 32'h80000000);
        end
        $display("select default test done");
        RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        rchk(32'h80000007, 32'hFFFFFFFF);
        $display("mid-run reset test done");
        tally_and_finish();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #40000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
bind led_gpio_pin_config led_gpio_checker u_chk (.MCLK, .RST, .BVALID,
    .RDATA, .RRESP, .RVALID, .LINK_UP, .ACTIVITY, .SPEED_100, .MII_RXD0,
    .MII_RXD1, .MII_RXD2, .MII_RXD3, .MII_CRS, .PHY_RESET_OUT, .PIN_O,
    .PIN_OE_N);
`default_nettype wire
